// ==== common/fwp_pkg.sv ====
/*
 * shared constants of the flash write-protect and secured otp block:
 * opcodes, register offsets, field positions, protect geometry, fsm states.
 * assumes a single clock domain and an 8-bit register port.
 */
`default_nettype none

package fwp_pkg;

	// ====================================================
	// serial command opcodes
	localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
	localparam logic [7:0] OPC_PAGE_PROGRAM  = 8'h02;
	localparam logic [7:0] OPC_SECTOR_ERASE  = 8'h20;
	localparam logic [7:0] OPC_POWER_DOWN    = 8'hb9;
	localparam logic [7:0] OPC_RELEASE_PD    = 8'hab;
	localparam logic [7:0] OPC_SIGNATURE     = 8'hab;
	localparam logic [7:0] OPC_SOFT_RESET    = 8'h99;
	localparam logic [7:0] OPC_OTP_ENTER     = 8'hb1;
	localparam logic [7:0] OPC_OTP_EXIT      = 8'hc1;
	localparam logic [7:0] OPC_SEC_REG_WRITE = 8'h2f;

	// ====================================================
	// register offsets
	localparam logic [3:0] REG_STATUS   = 4'h0;
	localparam logic [3:0] REG_SECURITY = 4'h1;
	localparam logic [3:0] REG_MODE     = 4'h2;
	localparam logic [3:0] REG_STATE    = 4'h3;

	// ====================================================
	// field positions
	localparam int ST_BUSY     = 0;
	localparam int ST_LATCH    = 1;
	localparam int ST_CODE_LSB = 2;
	localparam int ST_TB       = 6;
	localparam int ST_SRWD     = 7;
	localparam int SEC_FACTORY = 0;
	localparam int SEC_CUST    = 1;
	localparam int SEC_OTP     = 2;
	localparam int SEC_REFUSED = 3;
	localparam int MODE_QIO    = 0;
	localparam int MODE_QCMD   = 1;
	localparam int STA_PD      = 0;
	localparam int STA_FSM_LSB = 1;

	// ====================================================
	// geometry
	localparam int         ADDR_W       = 25;
	localparam int         BLOCK_LSB    = 16;
	localparam int         BLOCK_W      = 9;
	localparam int         OTP_W        = 9;
	localparam logic [9:0] BLOCK_TOTAL  = 10'h200;
	localparam logic [3:0] CODE_ALL     = 4'ha;
	localparam logic [8:0] OTP_SERIAL_LAST = 9'h00f;
	localparam logic [2:0] ADDR_BYTES   = 3'h4;

	// ====================================================
	// command fsm, gray along standby-opcode-address-data
	typedef enum logic [2:0] {
		ST_SBY = 3'b000,
		ST_OPC = 3'b001,
		ST_ADR = 3'b011,
		ST_DAT = 3'b010,
		ST_IGN = 3'b110
	} fwp_state_t;

endpackage

`default_nettype wire

// ==== rtl/fwp_serial_rx.sv ====
/*
 * serial byte receiver: synchronises chip select, clock and data pins,
 * samples data on clock rising edges, and reports bytes and frame edges.
 * assumes the system clock is well above four times the serial clock.
 */
`default_nettype none

module fwp_serial_rx
	import fwp_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       spiClk,
	input  wire logic       spiCsN,
	input  wire logic       spiSi,
	output var  logic       csFall,
	output var  logic       csRise,
	output var  logic       csAligned,
	output var  logic       byteDone,
	output var  logic [7:0] byteData
);

	logic [2:0] sclkSync_reg;
	logic [2:0] csSync_reg;
	logic [1:0] siSync_reg;
	logic [2:0] bitCount_reg;
	logic [7:0] shift_reg;
	logic       sclkRise;

	// ====================================================
	// pin synchronisers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sclkSync_reg <= 3'h0;
			csSync_reg   <= 3'h7;
			siSync_reg   <= 2'h0;
		end else begin
			sclkSync_reg <= {sclkSync_reg[1:0], spiClk};
			csSync_reg   <= {csSync_reg[1:0], spiCsN};
			siSync_reg   <= {siSync_reg[0], spiSi};
		end
	end

	assign sclkRise = sclkSync_reg[1] & ~sclkSync_reg[2] & ~csSync_reg[1];
	assign csFall   = ~csSync_reg[1] & csSync_reg[2];
	assign csRise   = csSync_reg[1] & ~csSync_reg[2];

	// ====================================================
	// bit and byte counting
	always_ff @(posedge sys_clk) begin
		if (!rst_n || csFall) begin
			bitCount_reg <= 3'h0;
			shift_reg    <= 8'h00;
		end else if (sclkRise) begin
			bitCount_reg <= bitCount_reg + 3'h1;
			shift_reg    <= {shift_reg[6:0], siSync_reg[1]};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			byteDone <= 1'b0;
			byteData <= 8'h00;
		end else begin
			byteDone <= sclkRise & (bitCount_reg == 3'h7);
			if (sclkRise && bitCount_reg == 3'h7) begin
				byteData <= {shift_reg[6:0], siSync_reg[1]};
			end
		end
	end

	assign csAligned = (bitCount_reg == 3'h0);

endmodule

`default_nettype wire

// ==== rtl/fwp_region.sv ====
/*
 * protected-region decoder: maps protect code, top/bottom select and a
 * 64k block index to a protected flag. purely combinational.
 */
`default_nettype none

module fwp_region
	import fwp_pkg::*;
(
	input  wire logic [3:0]         protectCode,
	input  wire logic               topBottom,
	input  wire logic [BLOCK_W-1:0] blockIdx,
	output logic                    isProtected
);

	logic [9:0] blockCount;

	always_comb begin
		if (protectCode == 4'h0) begin
			blockCount = 10'h000;
		end else if (protectCode >= CODE_ALL) begin
			blockCount = BLOCK_TOTAL;
		end else begin
			blockCount = 10'h001 << (protectCode - 4'h1);
		end
		if (topBottom) begin
			isProtected = {1'b0, blockIdx} < blockCount;
		end else begin
			isProtected = {1'b0, blockIdx} >= (BLOCK_TOTAL - blockCount);
		end
	end

endmodule

`default_nettype wire

// ==== rtl/fwp_write_protect.sv ====
/*
 * write-protect and secured otp control of a serial flash: command framing,
 * write-enable latch, power-down gating, block protection, otp locks.
 * assumes the array reports busy and loads program bytes into its page
 * buffer, committing them only on a write start.
 */
// Implementation choices: the register addresses and the strobed register port.
`default_nettype none

module fwp_write_protect
	import fwp_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [3:0]        regAddr,
	input  wire logic [7:0]        regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output var  logic [7:0]        regRdata,
	input  wire logic              spiClk,
	input  wire logic              spiCsN,
	input  wire logic              spiSi,
	input  wire logic              writeProtectPinIn,
	output logic                   writeProtectPinOut,
	output logic                   writeProtectPinOeN,
	input  wire logic              arrayBusy,
	input  wire logic              factoryLockFuse,
	input  wire logic              customerLockFuse,
	output var  logic              pageLoadValid,
	output var  logic [ADDR_W-1:0] pageLoadAddr,
	output var  logic [7:0]        pageLoadData,
	output var  logic              writeStart,
	output var  logic              writeErase,
	output var  logic              writeOtp,
	output var  logic [ADDR_W-1:0] writeAddr,
	output var  logic              customerLockBurn
);

	fwp_state_t        fsmState_reg;
	logic [7:0]        opcode_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [2:0]        addrCount_reg;
	logic [7:0]        offset_reg;
	logic              dataSeen_reg;
	logic [7:0]        statusData_reg;
	logic              writeEnableLatch_reg;
	logic [3:0]        protectCode_reg;
	logic              topBottom_reg;
	logic              statusProtect_reg;
	logic              factoryLock_reg;
	logic              customerLock_reg;
	logic              otpMode_reg;
	logic              refused_reg;
	logic              quadIo_reg;
	logic              quadCmd_reg;
	logic              powerDown_reg;
	logic [1:0]        wpSync_reg;
	logic              csFall;
	logic              csRise;
	logic              csAligned;
	logic              byteDone;
	logic [7:0]        byteData;
	logic              regionProtected;
	logic              hardwareProtectMode;
	logic              otpLocked;
	logic              exec;
	logic              isDataCmd;
	logic              programOk;
	logic              eraseOk;
	logic              statusOk;
	logic              lockOk;
	logic              refuse;

	// ====================================================
	// helpers
	function automatic logic hasAddress(input logic [7:0] op);
		return (op == OPC_PAGE_PROGRAM) || (op == OPC_SECTOR_ERASE);
	endfunction

	function automatic logic allowedInPowerDown(input logic [7:0] op);
		return (op == OPC_RELEASE_PD) || (op == OPC_SIGNATURE) || (op == OPC_SOFT_RESET);
	endfunction

	// ====================================================
	// serial receive and region decode
	fwp_serial_rx u_rx (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.spiClk    (spiClk),
		.spiCsN    (spiCsN),
		.spiSi     (spiSi),
		.csFall    (csFall),
		.csRise    (csRise),
		.csAligned (csAligned),
		.byteDone  (byteDone),
		.byteData  (byteData)
	);

	fwp_region u_region (
		.protectCode (protectCode_reg),
		.topBottom   (topBottom_reg),
		.blockIdx    (addr_reg[BLOCK_LSB +: BLOCK_W]),
		.isProtected (regionProtected)
	);

	// ====================================================
	// write-protect pin
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wpSync_reg <= 2'h3;
		end else begin
			wpSync_reg <= {wpSync_reg[0], writeProtectPinIn};
		end
	end

	// data line 2 role belongs to the quad data path; this block never drives it
	assign writeProtectPinOut = 1'b0;
	assign writeProtectPinOeN = 1'b1;

	assign hardwareProtectMode = ~wpSync_reg[1] & ~quadIo_reg & ~quadCmd_reg;

	// ====================================================
	// command framing
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fsmState_reg <= ST_SBY;
		end else if (csRise) begin
			fsmState_reg <= ST_SBY;
		end else if (csFall) begin
			fsmState_reg <= ST_OPC;
		end else if (byteDone) begin
			unique case (fsmState_reg)
				ST_OPC: begin
					if (powerDown_reg && !allowedInPowerDown(byteData)) begin
						fsmState_reg <= ST_IGN;
					end else if (hasAddress(byteData)) begin
						fsmState_reg <= ST_ADR;
					end else begin
						fsmState_reg <= ST_DAT;
					end
				end
				ST_ADR: begin
					if (addrCount_reg == ADDR_BYTES - 3'h1) begin
						fsmState_reg <= ST_DAT;
					end
				end
				ST_SBY, ST_DAT, ST_IGN: begin
					fsmState_reg <= fsmState_reg;
				end
				default: begin
					fsmState_reg <= ST_SBY;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n || csFall) begin
			opcode_reg     <= 8'h00;
			addr_reg       <= '0;
			addrCount_reg  <= 3'h0;
			offset_reg     <= 8'h00;
			dataSeen_reg   <= 1'b0;
			statusData_reg <= 8'h00;
		end else if (byteDone) begin
			if (fsmState_reg == ST_OPC) begin
				opcode_reg <= byteData;
			end
			if (fsmState_reg == ST_ADR) begin
				addr_reg      <= {addr_reg[ADDR_W-9:0], byteData};
				addrCount_reg <= addrCount_reg + 3'h1;
			end
			if (fsmState_reg == ST_DAT) begin
				dataSeen_reg   <= 1'b1;
				statusData_reg <= byteData;
				offset_reg     <= offset_reg + 8'h01;
			end
		end
	end

	// program bytes go to the page buffer; nothing is written until commit
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pageLoadValid <= 1'b0;
			pageLoadAddr  <= '0;
			pageLoadData  <= 8'h00;
		end else begin
			pageLoadValid <= byteDone && fsmState_reg == ST_DAT && opcode_reg == OPC_PAGE_PROGRAM;
			if (byteDone && fsmState_reg == ST_DAT) begin
				pageLoadAddr <= {addr_reg[ADDR_W-1:8], addr_reg[7:0] + offset_reg};
				pageLoadData <= byteData;
			end
		end
	end

	// ====================================================
	// execution checks
	assign exec = csRise & csAligned & (fsmState_reg == ST_DAT);

	assign isDataCmd = (opcode_reg == OPC_STATUS_WRITE) || (opcode_reg == OPC_PAGE_PROGRAM) ||
		(opcode_reg == OPC_SECTOR_ERASE) || (opcode_reg == OPC_SEC_REG_WRITE);

	assign otpLocked = (addr_reg[OTP_W-1:0] <= OTP_SERIAL_LAST) ? factoryLock_reg : customerLock_reg;

	assign programOk = writeEnableLatch_reg & ~arrayBusy & dataSeen_reg &
		(otpMode_reg ? ~otpLocked : ~regionProtected);
	assign eraseOk   = writeEnableLatch_reg & ~arrayBusy & ~dataSeen_reg &
		~otpMode_reg & ~regionProtected;
	assign statusOk  = writeEnableLatch_reg & ~arrayBusy & dataSeen_reg;
	assign lockOk    = writeEnableLatch_reg & ~arrayBusy;

	always_comb begin
		refuse = 1'b0;
		if (exec) begin
			unique case (opcode_reg)
				OPC_PAGE_PROGRAM:  refuse = ~programOk;
				OPC_SECTOR_ERASE:  refuse = ~eraseOk;
				OPC_STATUS_WRITE:  refuse = ~statusOk;
				OPC_SEC_REG_WRITE: refuse = ~lockOk;
				default:           refuse = 1'b0;
			endcase
		end
	end

	// ====================================================
	// array write start
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			writeStart <= 1'b0;
			writeErase <= 1'b0;
			writeOtp   <= 1'b0;
			writeAddr  <= '0;
		end else begin
			writeStart <= exec & ((opcode_reg == OPC_PAGE_PROGRAM && programOk) ||
				(opcode_reg == OPC_SECTOR_ERASE && eraseOk));
			if (exec) begin
				writeErase <= (opcode_reg == OPC_SECTOR_ERASE);
				writeOtp   <= otpMode_reg;
				writeAddr  <= otpMode_reg ? {{(ADDR_W-OTP_W){1'b0}}, addr_reg[OTP_W-1:0]} : addr_reg;
			end
		end
	end

	// ====================================================
	// write-enable latch
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			writeEnableLatch_reg <= 1'b0;
		end else if (exec && opcode_reg == OPC_WRITE_ENABLE) begin
			writeEnableLatch_reg <= 1'b1;
		end else if (exec && (isDataCmd || opcode_reg == OPC_WRITE_DISABLE || opcode_reg == OPC_SOFT_RESET)) begin
			writeEnableLatch_reg <= 1'b0;
		end
	end

	// ====================================================
	// protect code, top/bottom and status write-protect bit
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			protectCode_reg   <= 4'h0;
			topBottom_reg     <= 1'b0;
			statusProtect_reg <= 1'b0;
		end else if (exec && opcode_reg == OPC_STATUS_WRITE && statusOk) begin
			topBottom_reg <= statusData_reg[ST_TB];
			if (!hardwareProtectMode) begin
				protectCode_reg   <= statusData_reg[ST_CODE_LSB +: 4];
				statusProtect_reg <= statusData_reg[ST_SRWD];
			end
		end else if (regWrite && regAddr == REG_STATUS) begin
			topBottom_reg <= regWdata[ST_TB];
			if (!hardwareProtectMode) begin
				protectCode_reg   <= regWdata[ST_CODE_LSB +: 4];
				statusProtect_reg <= regWdata[ST_SRWD];
			end
		end
	end

	// ====================================================
	// otp locks and mode
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			factoryLock_reg  <= 1'b0;
			customerLock_reg <= 1'b0;
			customerLockBurn <= 1'b0;
		end else begin
			factoryLock_reg  <= factoryLock_reg | factoryLockFuse;
			customerLock_reg <= customerLock_reg | customerLockFuse |
				(exec & (opcode_reg == OPC_SEC_REG_WRITE) & lockOk);
			customerLockBurn <= exec & (opcode_reg == OPC_SEC_REG_WRITE) & lockOk & ~customerLock_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			otpMode_reg <= 1'b0;
		end else if (exec && opcode_reg == OPC_OTP_ENTER) begin
			otpMode_reg <= 1'b1;
		end else if (exec && (opcode_reg == OPC_OTP_EXIT || opcode_reg == OPC_SOFT_RESET)) begin
			otpMode_reg <= 1'b0;
		end
	end

	// ====================================================
	// power-down
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			powerDown_reg <= 1'b0;
		end else if (exec && allowedInPowerDown(opcode_reg)) begin
			powerDown_reg <= 1'b0;
		end else if (exec && opcode_reg == OPC_POWER_DOWN && !arrayBusy) begin
			powerDown_reg <= 1'b1;
		end
	end

	// ====================================================
	// mode and refused flag
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			quadIo_reg  <= 1'b0;
			quadCmd_reg <= 1'b0;
		end else if (regWrite && regAddr == REG_MODE) begin
			quadIo_reg  <= regWdata[MODE_QIO];
			quadCmd_reg <= regWdata[MODE_QCMD];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			refused_reg <= 1'b0;
		end else if (refuse) begin
			refused_reg <= 1'b1;
		end else if (regWrite && regAddr == REG_SECURITY && regWdata[SEC_REFUSED]) begin
			refused_reg <= 1'b0;
		end
	end

	// ====================================================
	// register read
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !regRead) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= 8'h00;
			unique case (regAddr)
				REG_STATUS: begin
					regRdata[ST_BUSY]          <= arrayBusy;
					regRdata[ST_LATCH]         <= writeEnableLatch_reg;
					regRdata[ST_CODE_LSB +: 4] <= protectCode_reg;
					regRdata[ST_TB]            <= topBottom_reg;
					regRdata[ST_SRWD]          <= statusProtect_reg;
				end
				REG_SECURITY: begin
					regRdata[SEC_FACTORY] <= factoryLock_reg;
					regRdata[SEC_CUST]    <= customerLock_reg;
					regRdata[SEC_OTP]     <= otpMode_reg;
					regRdata[SEC_REFUSED] <= refused_reg;
				end
				REG_MODE: begin
					regRdata[MODE_QIO]  <= quadIo_reg;
					regRdata[MODE_QCMD] <= quadCmd_reg;
				end
				REG_STATE: begin
					regRdata[STA_PD]            <= powerDown_reg;
					regRdata[STA_FSM_LSB +: 3] <= fsmState_reg;
				end
				default: begin
					regRdata <= 8'h00;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== sim/fwp_chk.sv ====
/*
 * checker of the write-protect block: output pulses, framing, otp limits.
 * assumes one clock domain and a synchronous active-low reset.
 */
`default_nettype none

module fwp_chk
	import fwp_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire logic              spiCsN,
	input wire logic [7:0]        regRdata,
	input wire logic              writeProtectPinOut,
	input wire logic              writeProtectPinOeN,
	input wire logic              factoryLockFuse,
	input wire logic              customerLockFuse,
	input wire logic              pageLoadValid,
	input wire logic              writeStart,
	input wire logic              writeErase,
	input wire logic              writeOtp,
	input wire logic [ADDR_W-1:0] writeAddr,
	input wire logic              customerLockBurn
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====================================================
	// assertions
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	reset_quiet_a: assert property ($rose(rst_n) |-> !writeStart && !customerLockBurn && regRdata == 8'h00)
		else $error("output active right after reset");
	exec_on_rise_a: assert property (writeStart || customerLockBurn |-> spiCsN)
		else $error("execute while chip select low");
	start_single_a: assert property (writeStart |=> !writeStart [*8])
		else $error("write start longer than one pulse");
	burn_single_a: assert property (customerLockBurn |=> !customerLockBurn [*8])
		else $error("lock burn longer than one pulse");
	load_in_frame_a: assert property (pageLoadValid |-> !spiCsN && !writeStart)
		else $error("page load outside a frame");
	otp_addr_a: assert property (writeStart && writeOtp |-> writeAddr[ADDR_W-1:OTP_W] == '0 && !writeErase)
		else $error("otp write reaches the main array");
	fac_lock_a: assert property (writeStart && writeOtp && factoryLockFuse |-> writeAddr[8:0] > OTP_SERIAL_LAST)
		else $error("write into factory locked otp");
	cust_lock_a: assert property (writeStart && writeOtp && customerLockFuse |-> writeAddr[8:0] <= OTP_SERIAL_LAST)
		else $error("write into customer locked otp");
	pin_released_a: assert property (writeProtectPinOeN && !writeProtectPinOut)
		else $error("write-protect pin driven");

	// ====================================================
	// covers
	cov_prog_c: cover property (writeStart && !writeErase && !writeOtp);
	cov_otp_c: cover property (writeStart && writeOtp);
	cov_burn_c: cover property (customerLockBurn);
endmodule

bind fwp_write_protect fwp_chk u_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .spiCsN(spiCsN), .regRdata(regRdata),
	.writeProtectPinOut(writeProtectPinOut), .writeProtectPinOeN(writeProtectPinOeN),
	.factoryLockFuse(factoryLockFuse), .customerLockFuse(customerLockFuse),
	.pageLoadValid(pageLoadValid), .writeStart(writeStart), .writeErase(writeErase),
	.writeOtp(writeOtp), .writeAddr(writeAddr), .customerLockBurn(customerLockBurn)
);

`default_nettype wire

// ==== sim/fwp_host.sv ====
/*
 * serial host model: sends frames of whole bytes plus optional stray bits, msb first, mode 0.
 * assumes the caller enters frame just after a sys_clk edge.
 */
`default_nettype none

module fwp_host (
	input  wire logic sys_clk,
	output var  logic spiClk,
	output var  logic spiCsN,
	output var  logic spiSi
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] buff [0:15];
	initial begin
		spiClk = 1'b0;
		spiCsN = 1'b1;
		spiSi = 1'b0;
	end
	task automatic tick();
		repeat (4) @(posedge sys_clk);
	endtask
	// n whole bytes, then xb stray bits
	task automatic frame(input int n, input int xb);
		int i;
		spiCsN <= 1'b0;
		tick();
		for (i = 0; i < n * 8 + xb; i++) begin
			spiSi <= buff[i / 8][7 - i % 8];
			tick();
			spiClk <= 1'b1;
			tick();
			spiClk <= 1'b0;
		end
		tick();
		spiCsN <= 1'b1;
		spiSi <= ~spiSi;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule

`default_nettype wire

// ==== sim/fwp_write_protect_tb.sv ====
/*
 * testbench of the write-protect block: register port, serial frames, locks.
 * assumes the host model as far side and the customer fuse following lock burns.
 */
`default_nettype none

module fwp_write_protect_tb import fwp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic              sys_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [3:0]        regAddr = 4'h0;
	logic [7:0]        regWdata = 8'h00;
	logic              regWrite = 1'b0;
	logic              regRead = 1'b0;
	logic              wpIn = 1'b1;
	logic              facFuse = 1'b0;
	logic              custFuse = 1'b0;
	logic [7:0]        regRdata;
	logic              spiClk, spiCsN, spiSi, pageLoadValid, writeStart, writeErase, writeOtp, burn;
	logic [ADDR_W-1:0] writeAddr;
	logic [ADDR_W-1:0] loadAddr;
	logic [7:0]        loadData;
	int                err_count = 0, checked = 0, starts = 0, burns = 0;

	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		starts <= starts + int'(writeStart === 1'b1);
		burns <= burns + int'(burn === 1'b1);
		if (burn === 1'b1) custFuse <= 1'b1;
	end

	fwp_host u_host (.sys_clk(sys_clk), .spiClk(spiClk), .spiCsN(spiCsN), .spiSi(spiSi));
	fwp_write_protect DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .spiClk(spiClk), .spiCsN(spiCsN), .spiSi(spiSi),
		.writeProtectPinIn(wpIn), .writeProtectPinOut(), .writeProtectPinOeN(), .arrayBusy(1'b0),
		.factoryLockFuse(facFuse), .customerLockFuse(custFuse), .pageLoadValid(pageLoadValid),
		.pageLoadAddr(loadAddr), .pageLoadData(loadData), .writeStart(writeStart), .writeErase(writeErase),
		.writeOtp(writeOtp), .writeAddr(writeAddr), .customerLockBurn(burn)
	);

	// ====================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	task automatic cmd(input logic [7:0] c);
		u_host.buff[0] = c;
		@(posedge sys_clk);
		u_host.frame(1, 0);
	endtask
	// optional write enable, opcode, 4 address bytes, nd data bytes; e = expected starts
	task automatic try(input logic [7:0] c, input logic [31:0] a, input int nd, input int xb, input bit we, input int e);
		int i;
		int s0;
		s0 = starts;
		if (we) cmd(OPC_WRITE_ENABLE);
		u_host.buff[0] = c;
		for (i = 0; i < 4; i++) u_host.buff[1 + i] = a[31 - 8 * i -: 8];
		for (i = 0; i < 3; i++) u_host.buff[5 + i] = 8'h5a;
		@(posedge sys_clk);
		u_host.frame(5 + nd, xb);
		chk(starts - s0, e);
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask

	// ====================================================
	// scenarios
	task automatic t_reset();
		rd(REG_STATUS, 8'h00);
		rd(REG_STATE, 8'h00);
		wr(4'h9, 8'hff);
		rd(4'h9, 8'h00);
	endtask
	task automatic t_wel();
		try(OPC_PAGE_PROGRAM, 32'h10000, 1, 0, 0, 0);
		rd(REG_SECURITY, 8'h08);
		wr(REG_SECURITY, 8'h08);
		try(OPC_PAGE_PROGRAM, 32'h10000, 1, 0, 1, 1);
		chk({writeErase, writeAddr}, 32'h10000);
		chk(loadAddr, 32'h10000);
		chk(loadData, 8'h5a);
		rd(REG_STATUS, 8'h00);
		try(OPC_SECTOR_ERASE, 32'h20000, 0, 3, 1, 0);
		try(OPC_SECTOR_ERASE, 32'h20000, 0, 0, 1, 1);
		chk(writeErase, 1);
	endtask
	task automatic t_region();
		int c;
		int t;
		int n;
		for (c = 0; c < 12; c++) for (t = 0; t < 2; t++) begin
			n = (c == 0) ? 0 : (c >= 10) ? 512 : 1 << (c - 1);
			wr(REG_STATUS, {1'b0, t[0], c[3:0], 2'b00});
			try(OPC_SECTOR_ERASE, {t ? 9'd0 : 9'd511, 16'h0}, 0, 0, 1, n == 0);
			if (n < 512) try(OPC_SECTOR_ERASE, {t ? n[8:0] : 9'd511 - n[8:0], 16'h0}, 0, 0, 1, 1);
		end
		wr(REG_STATUS, 8'h00);
	endtask
	task automatic t_hw();
		wpIn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		wr(REG_STATUS, 8'hbc);
		rd(REG_STATUS, 8'h00);
		wr(REG_MODE, 8'h01);
		wr(REG_STATUS, 8'hbc);
		rd(REG_STATUS, 8'hbc);
		wr(REG_MODE, 8'h02);
		wr(REG_STATUS, 8'h7c);
		rd(REG_STATUS, 8'h7c);
		wr(REG_MODE, 8'h00);
		wr(REG_STATUS, 8'h80);
		rd(REG_STATUS, 8'h3c);
		wpIn <= 1'b1;
		try(OPC_STATUS_WRITE, 32'h0, 0, 0, 0, 0);
		rd(REG_STATUS, 8'h3c);
		try(OPC_STATUS_WRITE, 32'h0, 0, 0, 1, 0);
		rd(REG_STATUS, 8'h00);
	endtask
	task automatic t_pd();
		cmd(OPC_POWER_DOWN);
		rd(REG_STATE, 8'h01);
		try(OPC_PAGE_PROGRAM, 32'h0, 1, 0, 1, 0);
		rd(REG_STATUS, 8'h00);
		cmd(OPC_RELEASE_PD);
		rd(REG_STATE, 8'h00);
	endtask
	task automatic t_otp();
		int b0;
		wr(REG_SECURITY, 8'h08);
		cmd(OPC_OTP_ENTER);
		rd(REG_SECURITY, 8'h04);
		try(OPC_PAGE_PROGRAM, 32'h1000010, 1, 0, 1, 1);
		chk({writeOtp, writeAddr}, 32'h2000010);
		try(OPC_SECTOR_ERASE, 32'h10, 0, 0, 1, 0);
		facFuse <= 1'b1;
		try(OPC_PAGE_PROGRAM, 32'h5, 1, 0, 1, 0);
		try(OPC_PAGE_PROGRAM, 32'h1ff, 1, 0, 1, 1);
		b0 = burns;
		cmd(OPC_WRITE_ENABLE);
		cmd(OPC_SEC_REG_WRITE);
		chk(burns - b0, 1);
		rd(REG_SECURITY, 8'h0f);
		try(OPC_PAGE_PROGRAM, 32'h20, 1, 0, 1, 0);
		cmd(OPC_OTP_EXIT);
		try(OPC_PAGE_PROGRAM, 32'h20, 1, 0, 1, 1);
		chk({writeOtp, writeAddr}, 32'h20);
		do_reset();
		rd(REG_SECURITY, 8'h03);
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk);
		err_count++;
		test_done();
	end
	initial begin
		do_reset();
		t_reset();
		t_wel();
		t_region();
		t_hw();
		t_pd();
		t_otp();
		test_done();
	end
endmodule

`default_nettype wire
